// File: verilog/tpp_pkg.sv
package tpp_pkg;
   // register map, byte-free word indices on the plain register port
   localparam logic [3:0] ADDR_TIMER_CONTROL = 4'h0;
   localparam logic [3:0] ADDR_CAPTURE_COMPARE_CONTROL = 4'h1;
   localparam logic [3:0] ADDR_OUTPUT_CONTROL_REG = 4'h2;
   localparam logic [3:0] ADDR_PRESCALE_SELECT = 4'h3;
   localparam logic [3:0] ADDR_COMPARE_A = 4'h4;
   localparam logic [3:0] ADDR_COMPARE_B = 4'h5;
   localparam logic [3:0] ADDR_TIMER_COUNT_VALUE = 4'h6;
   localparam logic [3:0] ADDR_MATCH_FLAGS = 4'h7;

   // timer_control fields
   localparam int TC_COUNT_ENABLE_POS = 0;
   localparam int TC_WIDTH_SELECT_POS = 1;
   localparam int TC_COMMAND_MODE_POS = 2;
   // capture_compare_control fields
   localparam int CC_MODE_LSB = 0;
   localparam int CC_CLEAR_B_POS = 2;
   localparam int CC_CLEAR_CAPTURE_POS = 3;
   // output_control_reg fields
   localparam int OC_ENABLE_A_POS = 0;
   localparam int OC_POLARITY_A_POS = 1;
   localparam int OC_ENABLE_B_POS = 2;
   localparam int OC_POLARITY_B_POS = 3;
   // match flag fields
   localparam int MF_A_POS = 0;
   localparam int MF_B_POS = 1;

   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] COMPARE_RESET = 16'hFFFF;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [3:0] PRESCALE_RESET = 4'h0;
   localparam logic [15:0] WRAP_NARROW = 16'h00FF;
   localparam logic [15:0] WRAP_WIDE = 16'hFFFF;
   localparam logic [3:0] PRESCALE_MAX_SELECT = 4'h8;
   // divide by 4 at select 0, doubling up to 1024 at select 8
   localparam int PRESCALE_BASE_SHIFT = 2;
   localparam int PRESCALE_WIDTH = 10;

   typedef enum logic [1:0]
   {
      MODE_TOGGLE = 2'b00,
      MODE_PWM_B = 2'b01,
      MODE_PWM = 2'b10,
      MODE_PPG = 2'b11
   } tpp_mode_type;
endpackage

// File: verilog/tpp_out_channel.sv
`timescale 1ns/10ps
// one output pin: one compare-match level change per period, forced levels when idle
module tpp_out_channel
   import tpp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic wave_mode,
   input wire logic running,
   input wire logic period_start,
   input wire logic end_match,
   input wire logic early_full,
   input wire logic output_enable_bit,
   input wire logic output_polarity_bit,
   output logic pin_level
);
   logic pulse_on;
   logic fired;
   logic next_pulse_on;
   logic next_fired;
   logic next_pin_level;

   always_comb
   begin
      next_pulse_on = pulse_on;
      next_fired = fired;
      if (period_start)
      begin
         next_pulse_on = 1'b1;
         next_fired = 1'b0;
      end
      else if (early_full)
      begin
         next_fired = 1'b1; // compare moved below count: stay active
      end
      else if (end_match && !fired)
      begin
         next_pulse_on = 1'b0;
         next_fired = 1'b1; // later matches this period are ignored
      end
      if (!output_enable_bit)
      begin
         next_pin_level = ~output_polarity_bit;
      end
      else if (wave_mode && !running)
      begin
         next_pin_level = output_polarity_bit; // halted: active level
      end
      else if (wave_mode)
      begin
         next_pin_level = next_pulse_on ? output_polarity_bit : ~output_polarity_bit;
      end
      else
      begin
         next_pin_level = pin_level;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         pulse_on <= 1'b0;
         fired <= 1'b0;
         pin_level <= 1'b1;
      end
      else
      begin
         pulse_on <= next_pulse_on;
         fired <= next_fired;
         pin_level <= next_pin_level;
      end
   end
endmodule

// File: verilog/tpp_timer.sv
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
// How it works
// - PWM period is one full count; output a width from compare_a, b from compare_b.
// - 8-bit width: period 256 count clocks, width equals compare value.
// - 16-bit width: period 65536 count clocks, width equals compare value.
// - count clock is ref_clk divided by 4 up to 1024 in powers of two.
// - each output changes on its compare match at most once per period.
// - compare written below current count gives 100% duty for that period.
// - halting the counter drives the active level on output a in PWM and PROGRAMMABLE_PULSE_MODE, on b in the PWM modes.
// - disabled output drives the inverse of its polarity bit.
// - PROGRAMMABLE_PULSE_MODE: period from compare_b, width from compare_a, output a only.
// - PROGRAMMABLE_PULSE_MODE period is compare_b plus one, width compare_a; software keeps 1..compare_b.
// - counter clears after the compare_b match in PROGRAMMABLE_PULSE_MODE when that clear option is selected.
// - enable bit lets output follow mode; clearing it forces a fixed level.
// - disabled level is high for polarity zero, low for polarity one.
module tpp_timer
   import tpp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   output logic [15:0] reg_rdata,
   output logic timer_output_a,
   output logic timer_output_b,
   output logic match_a_irq,
   output logic match_b_irq
);
   logic [7:0] timer_control;
   logic [7:0] capture_compare_control;
   logic [7:0] output_control_reg;
   logic [3:0] prescale_select;
   logic [15:0] compare_a;
   logic [15:0] compare_b;
   logic [15:0] timer_count_value;
   logic [PRESCALE_WIDTH-1:0] prescale_count;
   logic [7:0] next_timer_control;
   logic [7:0] next_capture_compare_control;
   logic [7:0] next_output_control_reg;
   logic [3:0] next_prescale_select;
   logic [15:0] next_compare_a;
   logic [15:0] next_compare_b;
   logic [15:0] next_timer_count_value;
   logic [PRESCALE_WIDTH-1:0] next_prescale_count;
   logic next_match_a_irq;
   logic next_match_b_irq;
   logic [15:0] next_reg_rdata;

   logic count_enable_bit;
   logic counter_width_select;
   logic clear_on_compare_b;
   logic clear_on_capture;
   tpp_mode_type mode;
   logic [15:0] wrap_value;
   logic [15:0] width_mask;
   logic [PRESCALE_WIDTH-1:0] tick_mask;
   logic count_tick;
   logic hit_a;
   logic hit_b;
   logic at_wrap;
   logic restart;
   logic wave_a;
   logic wave_b;
   logic write_a;
   logic write_b;
   logic early_a;
   logic early_b;
   logic at_compare_b;
   logic [15:0] count_next_tick;
   logic period_start;
   logic write_flags;
   logic [15:0] read_word;

   assign count_enable_bit = timer_control[TC_COUNT_ENABLE_POS];
   assign counter_width_select = timer_control[TC_WIDTH_SELECT_POS];
   assign clear_on_compare_b = capture_compare_control[CC_CLEAR_B_POS];
   assign clear_on_capture = capture_compare_control[CC_CLEAR_CAPTURE_POS];
   assign mode = tpp_mode_type'(capture_compare_control[CC_MODE_LSB +: 2]);
   assign wrap_value = counter_width_select ? WRAP_WIDE : WRAP_NARROW;
   assign width_mask = wrap_value;

   // tick every 2^(select+2) clocks; select above 8 saturates at 1024
   always_comb
   begin
      if (prescale_select > PRESCALE_MAX_SELECT)
      begin
         tick_mask = {PRESCALE_WIDTH{1'b1}};
      end
      else
      begin
         tick_mask = PRESCALE_WIDTH'((11'h001 << (prescale_select + 4'(PRESCALE_BASE_SHIFT))) - 11'h001);
      end
   end
   assign count_tick = count_enable_bit && ((prescale_count & tick_mask) == tick_mask);

   // a width of N count clocks covers counts 0..N-1, so the match lands as the count steps onto N
   assign count_next_tick = (timer_count_value + 16'h0001) & width_mask;
   assign hit_a = count_tick && (count_next_tick == (compare_a & width_mask));
   assign hit_b = count_tick && (count_next_tick == (compare_b & width_mask));
   assign at_wrap = (timer_count_value == wrap_value);
   // the PROGRAMMABLE_PULSE_MODE period runs through compare_b itself, hence compare_b plus one count clocks
   assign at_compare_b = count_tick && (timer_count_value == (compare_b & width_mask));
   // clear on b only in PROGRAMMABLE_PULSE_MODE; other clear sources are outside this block
   assign restart = count_tick && (at_wrap || (at_compare_b && clear_on_compare_b && mode == MODE_PPG));
   // a stopped counter sits at zero, so holding a period start opens the first pulse at once
   assign period_start = restart || !count_enable_bit;

   // PROGRAMMABLE_PULSE_MODE drives output a only; output b keeps its last level there
   assign wave_a = (mode == MODE_PWM) || (mode == MODE_PWM_B && 1'b0) || (mode == MODE_PPG);
   assign wave_b = (mode == MODE_PWM) || (mode == MODE_PWM_B);

   assign write_a = reg_write && reg_addr == ADDR_COMPARE_A;
   assign write_b = reg_write && reg_addr == ADDR_COMPARE_B;
   assign write_flags = reg_write && reg_addr == ADDR_MATCH_FLAGS;
   // new compare already passed in this period: no ending match will come
   assign early_a = write_a && ((reg_wdata & width_mask) < timer_count_value);
   assign early_b = write_b && mode != MODE_PPG && ((reg_wdata & width_mask) < timer_count_value);

   // register group: controls, compares and the read answer
   always_comb
   begin
      next_timer_control = timer_control;
      next_capture_compare_control = capture_compare_control;
      next_output_control_reg = output_control_reg;
      next_prescale_select = prescale_select;
      next_compare_a = compare_a;
      next_compare_b = compare_b;
      next_reg_rdata = 16'h0000;
      if (reg_write)
      begin
         unique case (reg_addr)
            ADDR_TIMER_CONTROL: next_timer_control = reg_wdata[7:0];
            ADDR_CAPTURE_COMPARE_CONTROL: next_capture_compare_control = reg_wdata[7:0];
            ADDR_OUTPUT_CONTROL_REG: next_output_control_reg = reg_wdata[7:0];
            ADDR_PRESCALE_SELECT: next_prescale_select = reg_wdata[3:0];
            ADDR_COMPARE_A: next_compare_a = reg_wdata;
            ADDR_COMPARE_B: next_compare_b = reg_wdata;
            default: ;
         endcase
      end
      if (reg_read)
      begin
         next_reg_rdata = read_word;
      end
   end

   // read mux apart, so the answer is zero outside the cycle after a read
   always_comb
   begin
      unique case (reg_addr)
         ADDR_TIMER_CONTROL: read_word = {8'h00, timer_control};
         ADDR_CAPTURE_COMPARE_CONTROL: read_word = {8'h00, capture_compare_control};
         ADDR_OUTPUT_CONTROL_REG: read_word = {8'h00, output_control_reg};
         ADDR_PRESCALE_SELECT: read_word = {12'h000, prescale_select};
         ADDR_COMPARE_A: read_word = compare_a;
         ADDR_COMPARE_B: read_word = compare_b;
         ADDR_TIMER_COUNT_VALUE: read_word = timer_count_value;
         ADDR_MATCH_FLAGS: read_word = {14'h0000, match_b_irq, match_a_irq};
         default: read_word = 16'h0000;
      endcase
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         timer_control <= CONTROL_RESET;
         capture_compare_control <= CONTROL_RESET;
         output_control_reg <= CONTROL_RESET;
         prescale_select <= PRESCALE_RESET;
         compare_a <= COMPARE_RESET;
         compare_b <= COMPARE_RESET;
         reg_rdata <= 16'h0000;
      end
      else
      begin
         timer_control <= next_timer_control;
         capture_compare_control <= next_capture_compare_control;
         output_control_reg <= next_output_control_reg;
         prescale_select <= next_prescale_select;
         compare_a <= next_compare_a;
         compare_b <= next_compare_b;
         reg_rdata <= next_reg_rdata;
      end
   end

   // flag group: write one to clear
   always_comb
   begin
      next_match_a_irq = match_a_irq;
      next_match_b_irq = match_b_irq;
      if (write_flags && reg_wdata[MF_A_POS])
      begin
         next_match_a_irq = 1'b0;
      end
      if (write_flags && reg_wdata[MF_B_POS])
      begin
         next_match_b_irq = 1'b0;
      end
      // set beats clear in the same cycle, so no match is lost
      if (hit_a)
      begin
         next_match_a_irq = 1'b1;
      end
      if (hit_b)
      begin
         next_match_b_irq = 1'b1;
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         match_a_irq <= 1'b0;
         match_b_irq <= 1'b0;
      end
      else
      begin
         match_a_irq <= next_match_a_irq;
         match_b_irq <= next_match_b_irq;
      end
   end

   // counter group: prescaler and count clear while stopped, so a start is in phase
   always_comb
   begin
      next_prescale_count = prescale_count;
      next_timer_count_value = timer_count_value;
      if (!count_enable_bit)
      begin
         next_prescale_count = '0;
         next_timer_count_value = COUNT_RESET;
      end
      else
      begin
         next_prescale_count = prescale_count + 1'b1;
         if (restart)
         begin
            next_timer_count_value = COUNT_RESET;
         end
         else if (count_tick)
         begin
            next_timer_count_value = timer_count_value + 16'h0001;
         end
      end
   end

   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         timer_count_value <= COUNT_RESET;
         prescale_count <= '0;
      end
      else
      begin
         timer_count_value <= next_timer_count_value;
         prescale_count <= next_prescale_count;
      end
   end

   // a: ends at compare_a in PWM and PROGRAMMABLE_PULSE_MODE
   tpp_out_channel chan_a
   (
      .ref_clk(ref_clk),
      .reset(reset),
      .wave_mode(wave_a),
      .running(count_enable_bit),
      .period_start(period_start),
      .end_match(hit_a),
      .early_full(early_a),
      .output_enable_bit(output_control_reg[OC_ENABLE_A_POS]),
      .output_polarity_bit(output_control_reg[OC_POLARITY_A_POS]),
      .pin_level(timer_output_a)
   );

   // b: ends at compare_b in PWM modes
   tpp_out_channel chan_b
   (
      .ref_clk(ref_clk),
      .reset(reset),
      .wave_mode(wave_b),
      .running(count_enable_bit),
      .period_start(period_start),
      .end_match(hit_b),
      .early_full(early_b),
      .output_enable_bit(output_control_reg[OC_ENABLE_B_POS]),
      .output_polarity_bit(output_control_reg[OC_POLARITY_B_POS]),
      .pin_level(timer_output_b)
   );

   // toggle mode, capture and command mode are not built here
   logic unused_bits;
   assign unused_bits = clear_on_capture ^ timer_control[TC_COMMAND_MODE_POS];
endmodule

// File: sim/tpp_timer_asserts.sv
`timescale 1ns/10ps
module tpp_timer_checker
   import tpp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [3:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_write,
   input wire logic reg_read,
   input wire logic [15:0] reg_rdata,
   input wire logic timer_output_a,
   input wire logic timer_output_b,
   input wire logic match_a_irq,
   input wire logic match_b_irq
);
   // enable, mode and output control as last written; two held copies give the pins time to follow
   logic [6:0] shadow, next_shadow, held, held2;
   wire logic settled = (shadow == held) && (held == held2);
   wire logic wr_flags = reg_write && reg_addr == ADDR_MATCH_FLAGS;
   wire logic wave_a = shadow[5:4] == MODE_PWM || shadow[5:4] == MODE_PPG;
   always_comb
   begin
      next_shadow = shadow;
      if (reg_write && reg_addr == ADDR_TIMER_CONTROL)
         next_shadow[6] = reg_wdata[TC_COUNT_ENABLE_POS];
      if (reg_write && reg_addr == ADDR_CAPTURE_COMPARE_CONTROL)
         next_shadow[5:4] = reg_wdata[CC_MODE_LSB +: 2];
      if (reg_write && reg_addr == ADDR_OUTPUT_CONTROL_REG)
         next_shadow[3:0] = reg_wdata[3:0];
   end
   always_ff @(posedge ref_clk or posedge reset)
   begin
      if (reset)
      begin
         shadow <= '0;
         held <= '0;
         held2 <= '0;
      end
      else
      begin
         shadow <= next_shadow;
         held <= shadow;
         held2 <= held;
      end
   end
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   sequence wr_cmp_a;
      reg_write && !reg_read && reg_addr == ADDR_COMPARE_A && reg_wdata[15:8] == 8'h00;
   endsequence
   sequence rd_cmp_a;
      reg_read && !reg_write && reg_addr == ADDR_COMPARE_A;
   endsequence
   AST_RDATA_IDLE: assert property (!reg_read |=> reg_rdata == 16'h0000)
      else $error("read data not zero outside a read answer");
   AST_UNMAPPED_ZERO: assert property (reg_read && reg_addr > ADDR_MATCH_FLAGS |=> reg_rdata == 16'h0000)
      else $error("unmapped read not zero");
   AST_COMPARE_READBACK: assert property (wr_cmp_a ##1 rd_cmp_a |=> reg_rdata == $past(reg_wdata, 2))
      else $error("compare a readback wrong");
   AST_FLAG_A_STICKY: assert property (match_a_irq && !(wr_flags && reg_wdata[MF_A_POS]) |=> match_a_irq)
      else $error("match a flag dropped");
   AST_FLAG_B_STICKY: assert property (match_b_irq && !(wr_flags && reg_wdata[MF_B_POS]) |=> match_b_irq)
      else $error("match b flag dropped");
   AST_DISABLED_A: assert property (settled && !shadow[OC_ENABLE_A_POS]
      |-> timer_output_a == !shadow[OC_POLARITY_A_POS])
      else $error("disabled output a level wrong");
   AST_DISABLED_B: assert property (settled && !shadow[OC_ENABLE_B_POS]
      |-> timer_output_b == !shadow[OC_POLARITY_B_POS])
      else $error("disabled output b level wrong");
   AST_STOP_ACTIVE: assert property (settled && !shadow[6] && wave_a && shadow[OC_ENABLE_A_POS]
      |-> timer_output_a == shadow[OC_POLARITY_A_POS])
      else $error("stopped output a not active");
endmodule
bind tpp_timer tpp_timer_checker chk (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
   .timer_output_a(timer_output_a), .timer_output_b(timer_output_b),
   .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));

// File: sim/tb_top.sv
`timescale 1ns/10ps
module tb_top
   import tpp_pkg::*;
;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic reg_write = 1'b0;
   logic reg_read = 1'b0;
   logic [15:0] reg_rdata;
   logic timer_output_a, timer_output_b, match_a_irq, match_b_irq;
   logic [15:0] rv;
   int checks = 0;
   int n_fail = 0;
   int hi, per;
   always #50 ref_clk = ~ref_clk;
   tpp_timer uut (.ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .timer_output_a(timer_output_a),
      .timer_output_b(timer_output_b), .match_a_irq(match_a_irq), .match_b_irq(match_b_irq));
   task end_sim;
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task cmp16(input string nm, input logic [15:0] e, input logic [15:0] g);
      checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("MISMATCH %s exp=%h got=%h", nm, e, g);
      end
   endtask
   task cmpi(input string nm, input int e, input int g);
      checks++;
      if (g != e)
      begin
         n_fail++;
         $display("MISMATCH %s exp=%0d got=%0d", nm, e, g);
      end
   endtask
   task wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_write <= 1'b0;
   endtask
   task rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      @(negedge ref_clk);
      d = reg_rdata;
   endtask
   // counts cycles until the pin shows lvl; a compare_a write may be slipped in at cycle poke
   task automatic run_until(input bit sel, input logic lvl, input int poke, output int n);
      n = 0;
      while ((sel ? timer_output_b : timer_output_a) !== lvl)
      begin
         @(posedge ref_clk);
         reg_write <= (n == poke);
         @(negedge ref_clk);
         n++;
         if (n > 20000)
         begin
            n_fail++;
            end_sim;
         end
      end
   endtask
   task automatic meas(input bit sel, input int poke, input logic [15:0] pv, output int h, output int p);
      int n;
      @(posedge ref_clk);
      reg_addr <= ADDR_COMPARE_A;
      reg_wdata <= pv;
      @(negedge ref_clk);
      run_until(sel, 1'b0, -1, n);
      run_until(sel, 1'b1, -1, n);
      run_until(sel, 1'b0, poke, h);
      run_until(sel, 1'b1, -1, n);
      p = h + n;
   endtask
   task wait_flag_a;
      int k;
      k = 0;
      while (match_a_irq !== 1'b1)
      begin
         @(negedge ref_clk);
         k++;
         if (k > 20000)
         begin
            n_fail++;
            end_sim;
         end
      end
   endtask
   task t_reset;
      cmp16("out a", 16'h0001, {15'h0000, timer_output_a});
      cmp16("out b", 16'h0001, {15'h0000, timer_output_b});
      rd(ADDR_COMPARE_A, rv);
      cmp16("compare a", 16'hFFFF, rv);
      rd(ADDR_TIMER_COUNT_VALUE, rv);
      cmp16("count", 16'h0000, rv);
      rd(ADDR_MATCH_FLAGS, rv);
      cmp16("flags", 16'h0000, rv);
      rd(4'hC, rv);
      cmp16("unmapped", 16'h0000, rv);
   endtask
   task t_readback;
      @(posedge ref_clk);
      reg_write <= 1'b1;
      reg_addr <= ADDR_COMPARE_A;
      reg_wdata <= 16'h0033;
      @(posedge ref_clk);
      reg_write <= 1'b0;
      reg_read <= 1'b1;
      @(posedge ref_clk);
      reg_read <= 1'b0;
      @(negedge ref_clk);
      cmp16("compare a back", 16'h0033, reg_rdata);
   endtask
   task t_pwm8;
      wr(ADDR_CAPTURE_COMPARE_CONTROL, 16'h0002);
      wr(ADDR_COMPARE_A, 16'h0040);
      wr(ADDR_COMPARE_B, 16'h0080);
      wr(ADDR_OUTPUT_CONTROL_REG, 16'h000F);
      wr(ADDR_TIMER_CONTROL, 16'h0001);
      meas(1'b1, -1, 16'h0040, hi, per);
      cmpi("pwm b width", 512, hi);
      cmpi("pwm b period", 1024, per);
      for (int s = 0; s < 3; s++)
      begin
         wr(ADDR_PRESCALE_SELECT, 16'(s));
         meas(1'b0, -1, 16'h0040, hi, per);
         cmpi("pwm a width", 64 * (4 << s), hi);
         cmpi("pwm a period", 256 * (4 << s), per);
      end
   endtask
   task t_full;
      wr(ADDR_PRESCALE_SELECT, 16'h0000);
      wr(ADDR_MATCH_FLAGS, 16'h0001);
      wait_flag_a;
      // rewrite from the match: the later match at 0x80 must not move the pin again
      wr(ADDR_COMPARE_A, 16'h0080);
      // lowered to 0x20 near count 0x60: stays active to the wrap, then 0x20 next period
      meas(1'b0, 384, 16'h0020, hi, per);
      cmpi("full duty width", 1152, hi);
   endtask
   task t_wide;
      wr(ADDR_TIMER_CONTROL, 16'h0003);
      repeat (1100) @(posedge ref_clk);
      rd(ADDR_TIMER_COUNT_VALUE, rv);
      cmp16("count past 8 bits", 16'h0001, {15'h0000, rv > 16'h00FF});
   endtask
   task t_ppg;
      wr(ADDR_TIMER_CONTROL, 16'h0000);
      wr(ADDR_MATCH_FLAGS, 16'h0003);
      wr(ADDR_CAPTURE_COMPARE_CONTROL, 16'h0007);
      wr(ADDR_COMPARE_B, 16'h0009);
      wr(ADDR_COMPARE_A, 16'h0003);
      wr(ADDR_TIMER_CONTROL, 16'h0001);
      meas(1'b0, -1, 16'h0003, hi, per);
      cmpi("ppg width", 12, hi);
      cmpi("ppg period", 40, per);
      cmp16("flag a", 16'h0001, {15'h0000, match_a_irq});
      cmp16("flag b", 16'h0001, {15'h0000, match_b_irq});
   endtask
   task t_stop;
      wr(ADDR_TIMER_CONTROL, 16'h0000);
      repeat (4) @(posedge ref_clk);
      @(negedge ref_clk);
      cmp16("stopped a", 16'h0001, {15'h0000, timer_output_a});
      rd(ADDR_TIMER_COUNT_VALUE, rv);
      cmp16("stopped count", 16'h0000, rv);
      wr(ADDR_MATCH_FLAGS, 16'h0003);
      rd(ADDR_MATCH_FLAGS, rv);
      cmp16("flags cleared", 16'h0000, rv);
      wr(ADDR_OUTPUT_CONTROL_REG, 16'h0002);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      cmp16("disabled a", 16'h0000, {15'h0000, timer_output_a});
      cmp16("disabled b", 16'h0001, {15'h0000, timer_output_b});
   endtask
   initial
   begin
      repeat (2) @(posedge ref_clk);
      reset <= 1'b0;
      t_reset;
      t_readback;
      t_pwm8;
      t_full;
      t_wide;
      t_ppg;
      t_stop;
      end_sim;
   end
endmodule
